// ---- eew_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module eew_slave #(
  parameter int          TWC_CYCLES_P = eew_pkg::TWC_CYCLES,
  parameter bit          REDUCED_PIN  = 1'b0,
  parameter logic [3:0]  DEV_CODE     = eew_pkg::DEV_TYPE_CODE
) (
  input  wire logic                      mclk_in,
  input  wire logic                      srst_in,
  input  wire logic                      link_clk_in,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_out,
  input  wire logic                      chip_select_bit0_in,
  input  wire logic                      chip_select_bit1_in,
  input  wire logic                      chip_select_bit2_in,
  input  wire logic                      wp_in,
  output logic                           busy_out,
  output logic                           read_selected_out,
  output logic [eew_pkg::ADDR_W-1:0]     word_ptr_out,
  input  wire logic [eew_pkg::ADDR_W-1:0] mem_rd_addr_in,
  output logic [7:0]                     mem_rd_data_out
);
  import eew_pkg::*;

  // Link domain reset and pin synchronisers
  logic       lrst_s1_reg;
  logic       lrst_reg;
  logic [1:0] scl_s_reg;
  logic [1:0] sda_s_reg;
  logic [1:0] wp_s_reg;
  logic [1:0] busy_s_reg;
  logic [2:0] cs_s1_reg;
  logic [2:0] cs_s2_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge link_clk_in)
  begin
    lrst_s1_reg <= srst_in;
    lrst_reg    <= lrst_s1_reg;
    scl_s_reg   <= {scl_s_reg[0], scl_in};
    sda_s_reg   <= {sda_s_reg[0], sda_in};
    wp_s_reg    <= {wp_s_reg[0], wp_in};
    cs_s1_reg   <= {chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in};
    cs_s2_reg   <= cs_s1_reg;
    scl_d_reg   <= scl_s_reg[1];
    sda_d_reg   <= sda_s_reg[1];
  end

  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_now   = scl_s_reg[1];
  assign sda_now   = sda_s_reg[1];
  assign scl_rise  = scl_now & ~scl_d_reg;
  assign scl_fall  = ~scl_now & scl_d_reg;
  assign start_det = scl_now & scl_d_reg & sda_d_reg & ~sda_now;
  assign stop_det  = scl_now & scl_d_reg & ~sda_d_reg & sda_now;

  // Chip select compare
  function automatic logic cs_match(input logic [2:0] sent, input logic [2:0] pins,
                                    input logic reduced);
    logic [2:0] want;
    want = pins;
    if (reduced)
    begin
      want[1:0] = 2'b00;
    end
    return sent == want;
  endfunction : cs_match

  // Link protocol engine
  eew_link_state_t state_reg;
  logic [7:0]      shift_reg;
  logic [3:0]      bit_cnt_reg;
  logic [1:0]      byte_idx_reg;
  logic            sel_write_reg;
  logic            sel_read_reg;
  logic            oe_reg;
  logic            ev_tog_reg;
  eew_event_t      ev_reg;
  logic            link_busy;
  logic            ctrl_ok;

  // Busy refuses new control bytes
  assign link_busy = busy_s_reg[1];
  assign ctrl_ok   = (shift_reg[7:4] == DEV_CODE)
                   & cs_match(shift_reg[3:1], cs_s2_reg, REDUCED_PIN)
                   & ~link_busy;

  always_ff @(posedge link_clk_in)
  begin
    busy_s_reg <= {busy_s_reg[0], busy_out};
  end

  always_ff @(posedge link_clk_in)
  begin
    if (lrst_reg)
    begin
      state_reg     <= LS_IDLE;
      shift_reg     <= BYTE_RESET;
      bit_cnt_reg   <= 4'h0;
      byte_idx_reg  <= IDX_CTRL;
      sel_write_reg <= 1'b0;
      sel_read_reg  <= 1'b0;
      oe_reg        <= 1'b0;
      ev_tog_reg    <= 1'b0;
      ev_reg        <= '{kind: EV_STOP, data: BYTE_RESET, wp: 1'b0};
    end
    else if (start_det)
    begin
      state_reg     <= LS_RECV;
      bit_cnt_reg   <= 4'h0;
      byte_idx_reg  <= IDX_CTRL;
      sel_write_reg <= 1'b0;
      sel_read_reg  <= 1'b0;
      oe_reg        <= 1'b0;
    end
    // Stop commits only an addressed write
    else if (stop_det)
    begin
      state_reg    <= LS_IDLE;
      oe_reg       <= 1'b0;
      sel_read_reg <= 1'b0;
      if (sel_write_reg)
      begin
        ev_reg     <= '{kind: EV_STOP, data: BYTE_RESET, wp: wp_s_reg[1]};
        ev_tog_reg <= ~ev_tog_reg;
      end
      sel_write_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        LS_RECV:
        begin
          if (scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda_now};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE)
          begin
            bit_cnt_reg <= 4'h0;
            if (byte_idx_reg == IDX_CTRL)
            begin
              oe_reg        <= ctrl_ok;
              state_reg     <= ctrl_ok ? LS_ACK : LS_SKIP;
              sel_write_reg <= ctrl_ok & ~shift_reg[0];
              sel_read_reg  <= ctrl_ok & shift_reg[0];
            end
            else
            begin
              oe_reg     <= 1'b1;
              state_reg  <= LS_ACK;
              ev_tog_reg <= ~ev_tog_reg;
              case (byte_idx_reg)
                IDX_HI:  ev_reg <= '{kind: EV_ADDR_HI, data: shift_reg, wp: 1'b0};
                IDX_LO:  ev_reg <= '{kind: EV_ADDR_LO, data: shift_reg, wp: 1'b0};
                default: ev_reg <= '{kind: EV_DATA, data: shift_reg, wp: 1'b0};
              endcase
            end
          end
        end
        LS_ACK:
        begin
          if (scl_fall)
          begin
            oe_reg <= 1'b0;
            if (byte_idx_reg != IDX_DATA)
            begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
            state_reg <= sel_read_reg ? LS_SKIP : LS_RECV;
          end
        end
        LS_SKIP:
        begin
          oe_reg <= 1'b0;
        end
        default:
        begin
          oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out           = 1'b0;
  assign sda_oe_out        = oe_reg;
  assign read_selected_out = sel_read_reg;

  // Event crossing into the system clock domain
  logic [2:0] ev_s_reg;
  logic       ev_strobe;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ev_s_reg <= 3'h0;
    end
    else
    begin
      ev_s_reg <= {ev_s_reg[1:0], ev_tog_reg};
    end
  end

  // One pulse per toggle; ev_reg already stable
  assign ev_strobe = ev_s_reg[2] ^ ev_s_reg[1];

  // Pointer, page buffer and array
  logic [7:0]            mem_reg [0:(1 << ADDR_W)-1];
  logic [7:0]            page_reg [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [ADDR_W-1:0]     ptr_reg;
  logic                  busy_reg;
  logic                  copy_reg;
  logic [PAGE_W-1:0]     copy_idx_reg;
  logic [TIMER_W-1:0]    timer_reg;

  // Last count of the timed write cycle
  localparam logic [TIMER_W-1:0] TWC_LAST = TIMER_W'(TWC_CYCLES_P - 1);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ptr_reg <= PTR_RESET;
    end
    else if (ev_strobe)
    begin
      case (ev_reg.kind)
        EV_ADDR_HI: ptr_reg[ADDR_W-1:8] <= ev_reg.data[6:0];
        EV_ADDR_LO: ptr_reg[7:0] <= ev_reg.data;
        EV_DATA:    ptr_reg[PAGE_W-1:0] <= ptr_reg[PAGE_W-1:0] + 6'h01;
        default:    ptr_reg <= ptr_reg;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (ev_strobe && ev_reg.kind == EV_DATA)
    begin
      page_reg[ptr_reg[PAGE_W-1:0]] <= ev_reg.data;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      mask_reg <= '0;
    end
    else if (ev_strobe && ev_reg.kind == EV_ADDR_HI)
    begin
      mask_reg <= '0;
    end
    else if (ev_strobe && ev_reg.kind == EV_DATA)
    begin
      mask_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
    end
    else if (ev_strobe && ev_reg.kind == EV_STOP && ev_reg.wp)
    begin
      mask_reg <= '0;
    end
    else if (copy_reg && copy_idx_reg == 6'h3F)
    begin
      mask_reg <= '0;
    end
  end

  // Timed write cycle
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      busy_reg     <= 1'b0;
      copy_reg     <= 1'b0;
      copy_idx_reg <= 6'h00;
      timer_reg    <= '0;
    end
    else if (!busy_reg)
    begin
      if (ev_strobe && ev_reg.kind == EV_STOP && !ev_reg.wp && |mask_reg)
      begin
        busy_reg     <= 1'b1;
        copy_reg     <= 1'b1;
        copy_idx_reg <= 6'h00;
        timer_reg    <= '0;
      end
    end
    else
    begin
      timer_reg <= timer_reg + 1'b1;
      if (timer_reg == TWC_LAST)
      begin
        busy_reg <= 1'b0;
      end
      if (copy_reg)
      begin
        copy_idx_reg <= copy_idx_reg + 6'h01;
        if (copy_idx_reg == 6'h3F)
        begin
          copy_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (copy_reg && mask_reg[copy_idx_reg])
    begin
      mem_reg[{ptr_reg[ADDR_W-1:PAGE_W], copy_idx_reg}] <= page_reg[copy_idx_reg];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      mem_rd_data_out <= BYTE_RESET;
    end
    else
    begin
      mem_rd_data_out <= mem_reg[mem_rd_addr_in];
    end
  end

  assign busy_out     = busy_reg;
  assign word_ptr_out = ptr_reg;

endmodule : eew_slave
`default_nettype wire

// ---- eew_pkg.sv ----
// What this block does
// - Data changes only while clock low
// - Falling data, clock high, means start
// - Rising data, clock high, means stop
// - One bit per clock, sampled clock high
// - Acknowledge after every received address and data byte
// - No acknowledge during write cycle
// - Acknowledge holds data low through high
// - Read sends no data bytes, line released after control ack
// - Control byte: type, selects, direction
// - Select bits must equal address inputs
// - Direction bit one reads, zero writes
// - Two address bytes, high first, fifteen bits
// - Acknowledge control byte only on match
// - Reduced-pin option matches low selects as zero
// - Pointer wraps within own array
// - Byte write acknowledged, stop starts cycle
// - Protected write acknowledged but discarded
// - Protect blocks writes only, never reads
// - Pointer ends after last written byte
// - Up to 64 bytes buffered until stop
// - Data bytes step only low six bits
// - Write cycle ends within 5 ms
// - Protect sampled at stop only
`default_nettype none
package eew_pkg;

  localparam int          CLK_HZ        = 20_000_000;
  localparam int          TWC_MS        = 5;
  localparam int          TWC_CYCLES    = TWC_MS * (CLK_HZ / 1000);
  localparam int          TIMER_W       = 24;
  localparam int          ADDR_W        = 15;
  localparam int          PAGE_W        = 6;
  localparam int          PAGE_BYTES    = 64;
  localparam logic [3:0]  DEV_TYPE_CODE = 4'h5;  // Arbitrary value
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [14:0] PTR_RESET     = 15'h0000;
  localparam logic [1:0]  IDX_CTRL      = 2'h0;
  localparam logic [1:0]  IDX_HI        = 2'h1;
  localparam logic [1:0]  IDX_LO        = 2'h2;
  localparam logic [1:0]  IDX_DATA      = 2'h3;

  typedef enum logic [1:0] {EV_ADDR_HI, EV_ADDR_LO, EV_DATA, EV_STOP} eew_ev_kind_t;

  typedef enum logic [1:0] {LS_IDLE, LS_RECV, LS_ACK, LS_SKIP} eew_link_state_t;

  typedef struct packed {
    eew_ev_kind_t kind;
    logic [7:0]   data;
    logic         wp;
  } eew_event_t;

endpackage : eew_pkg
`default_nettype wire

// ---- eew_slave_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module eew_chk #(
  parameter int TWC_CYCLES_P = 200
) (
  input wire logic                        mclk_in,
  input wire logic                        srst_in,
  input wire logic                        link_clk_in,
  input wire logic                        scl_in,
  input wire logic                        sda_out,
  input wire logic                        sda_oe_out,
  input wire logic                        busy_out,
  input wire logic [eew_pkg::ADDR_W-1:0]  word_ptr_out,
  input wire logic [eew_pkg::ADDR_W-1:0]  mem_rd_addr_in,
  input wire logic [7:0]                  mem_rd_data_out
);
  import eew_pkg::*;
  int cnt_reg;
  // Busy length count
  always_ff @(posedge mclk_in)
    if (srst_in || !busy_out) cnt_reg <= 0;
    else cnt_reg <= cnt_reg + 1;
  chk_open_drain: assert property (@(posedge link_clk_in) disable iff (srst_in)
    sda_out == 1'b0) else $error("data pin driven high");
  chk_ack_in_low: assert property (@(posedge link_clk_in) disable iff (srst_in)
    $rose(sda_oe_out) |-> !scl_in) else $error("ack raised with clock high");
  chk_ack_out_low: assert property (@(posedge link_clk_in) disable iff (srst_in)
    $fell(sda_oe_out) |-> !scl_in) else $error("ack dropped with clock high");
  chk_ack_width: assert property (@(posedge link_clk_in) disable iff (srst_in)
    $rose(sda_oe_out) |-> sda_oe_out [*8]) else $error("ack too short");
  chk_ack_not_busy: assert property (@(posedge link_clk_in) disable iff (srst_in)
    $rose(sda_oe_out) |-> !busy_out) else $error("ack during write cycle");
  chk_busy_len: assert property (@(posedge mclk_in) disable iff (srst_in)
    $fell(busy_out) |-> cnt_reg == TWC_CYCLES_P)
    else $error("write cycle length wrong");
  chk_busy_bound: assert property (@(posedge mclk_in) disable iff (srst_in)
    $rose(busy_out) |-> ##[1:1000] !busy_out) else $error("write cycle never ends");
  chk_ptr_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
    busy_out && $past(busy_out) |-> $stable(word_ptr_out)) else $error("pointer moved");
  chk_array_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
    !busy_out && !$past(busy_out) && !$past(busy_out, 2) && !$past(srst_in)
    && $stable(mem_rd_addr_in) |=> $stable(mem_rd_data_out)) else $error("array changed");
  cover property (@(posedge mclk_in) $rose(busy_out));
  cover property (@(posedge link_clk_in) $rose(sda_oe_out));
  cover property (@(posedge mclk_in) $changed(word_ptr_out));
endmodule : eew_chk
`default_nettype wire

// ---- eew_mstr.sv ----
`timescale 1ns/1ps
`default_nettype none
module eew_mstr (
  input  wire logic mclk_in,
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial scl_out = 1'b1;
  initial sda_out = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic xbit(input logic v, output logic s);
    sda_out = v;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    s = sda_wire_in;
    scl_out = 1'b0;
    tick(2);
  endtask : xbit
  task automatic start_c;
    sda_out = 1'b1;
    tick(1);
    scl_out = 1'b1;
    tick(2);
    sda_out = 1'b0;
    tick(2);
    scl_out = 1'b0;
    tick(2);
  endtask : start_c
  task automatic stop_c;
    sda_out = 1'b0;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_out = 1'b1;
    tick(4);
  endtask : stop_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, s);
    ack = !s;
  endtask : put_byte
endmodule : eew_mstr
`default_nettype wire

// ---- eew_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module tb;
  import eew_pkg::*;
  localparam int TWC = 200;
  localparam logic [3:0] RP_CODE = 4'h6;  // Arbitrary value
  logic mclk_in = 1'b0, lk = 1'b0, srst_in = 1'b1, wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic [14:0] rd_a = 15'h0012, ptr;
  logic m_scl, m_sda, sda_o, sda_oe, busy, rsel, rp_o, rp_oe;
  logic [7:0] rd_d;
  logic [7:0] pg[64];
  logic [15:0] q[$];
  logic [15:0] obs, exp_v;
  wire logic sda_w = m_sda & (sda_oe ? sda_o : 1'b1) & (rp_oe ? rp_o : 1'b1);
  int failures = 0, checked = 0;
  event got;
  always #25 mclk_in = ~mclk_in;
  initial begin #3.1; forever #6 lk = ~lk; end
  eew_mstr u_mst (.mclk_in(mclk_in), .sda_wire_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
  eew_slave #(.TWC_CYCLES_P(TWC)) u_dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .link_clk_in(lk), .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .chip_select_bit0_in(cs[0]), .chip_select_bit1_in(cs[1]), .chip_select_bit2_in(cs[2]),
    .wp_in(wp), .busy_out(busy), .read_selected_out(rsel), .word_ptr_out(ptr),
    .mem_rd_addr_in(rd_a), .mem_rd_data_out(rd_d));
  eew_slave #(.TWC_CYCLES_P(TWC), .REDUCED_PIN(1'b1), .DEV_CODE(RP_CODE)) u_dut_rp (
    .mclk_in(mclk_in), .srst_in(srst_in), .link_clk_in(lk), .scl_in(m_scl), .sda_in(sda_w),
    .sda_out(rp_o), .sda_oe_out(rp_oe), .chip_select_bit0_in(cs[0]),
    .chip_select_bit1_in(cs[1]), .chip_select_bit2_in(cs[2]), .wp_in(wp), .busy_out(),
    .read_selected_out(), .word_ptr_out(), .mem_rd_addr_in(rd_a), .mem_rd_data_out());
  task automatic note(input logic [15:0] e);
    q.push_back(e);
  endtask : note
  task automatic see(input logic [15:0] v);
    obs = v;
    ->got;
    u_mst.tick(1);
  endtask : see
  always @(got)
  begin
    exp_v = q.pop_front();
    `CHK(obs, exp_v)
  end
  task automatic xb(input bit st, input logic [7:0] b, input logic e);
    logic a;
    if (st) u_mst.start_c;
    u_mst.put_byte(b, a);
    note(e);
    see(a);
  endtask : xb
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    rd_a = a;
    u_mst.tick(3);
    note(e);
    see(rd_d);
  endtask : rd
  task automatic wcyc(input logic e);
    logic r;
    r = 1'b0;
    repeat (40) begin u_mst.tick(1); if (busy === 1'b1) r = 1'b1; end
    note(e);
    see(r);
    repeat (400) if (busy === 1'b1) u_mst.tick(1);
  endtask : wcyc
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic end_sim;
    #1;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    logic [7:0] d;
    void'($urandom(60));
    cs = 3'($urandom);
    repeat (12) @(posedge mclk_in);
    #1 srst_in = 1'b0;
    u_mst.tick(4);
    xb(1, {DEV_TYPE_CODE ^ 4'h1, cs, 1'b0}, 0);
    for (int i = 0; i < 3; i++) xb(1, {DEV_TYPE_CODE, cs ^ (3'h1 << i), 1'b0}, 0);
    xb(1, {DEV_TYPE_CODE, cs, 1'b1}, 1);
    note(1); see(rsel);
    u_mst.stop_c;
    xb(1, {RP_CODE, cs[2], 2'b00, 1'b0}, 1);
    xb(1, {RP_CODE, cs[2], 2'b01, 1'b0}, 0);
    xb(1, {RP_CODE, ~cs[2], 2'b00, 1'b0}, 0);
    u_mst.stop_c;
    done("select");
    d = 8'($urandom);
    xb(1, {DEV_TYPE_CODE, cs, 1'b0}, 1);
    xb(0, 8'h80, 1);
    xb(0, 8'h12, 1);
    xb(0, d, 1);
    u_mst.stop_c;
    wp = 1'b1;
    xb(1, {DEV_TYPE_CODE, cs, 1'b0}, 0);
    u_mst.stop_c;
    wcyc(1);
    note(16'h0013); see(ptr);
    rd(15'h0012, d);
    done("byte");
    xb(1, {DEV_TYPE_CODE, cs, 1'b0}, 1);
    xb(0, 8'h00, 1);
    xb(0, 8'h12, 1);
    xb(0, ~d, 1);
    u_mst.stop_c;
    wcyc(0);
    rd(15'h0012, d);
    xb(1, {DEV_TYPE_CODE, cs, 1'b1}, 1);
    u_mst.stop_c;
    wp = 1'b0;
    done("protect");
    xb(1, {DEV_TYPE_CODE, cs, 1'b0}, 1);
    xb(0, 8'h01, 1);
    xb(0, 8'h7E, 1);
    for (int k = 0; k < 66; k++)
    begin
      d = 8'($urandom);
      pg[(62 + k) % 64] = d;
      xb(0, d, 1);
    end
    u_mst.stop_c;
    wcyc(1);
    note(16'h0140); see(ptr);
    for (int k = 0; k < 64; k++) rd(15'h0140 + 15'(k), pg[k]);
    done("page");
    end_sim;
  end
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    failures++;
    end_sim;
  end
endmodule : tb
bind eew_slave eew_chk #(.TWC_CYCLES_P(TWC_CYCLES_P)) u_chk (.mclk_in, .srst_in,
  .link_clk_in, .scl_in, .sda_out, .sda_oe_out, .busy_out, .word_ptr_out,
  .mem_rd_addr_in, .mem_rd_data_out);
`default_nettype wire
